//--- rtl/odac_ctrl.sv
// Digital control of an eight-channel DAC written over a two-wire serial bus.
// Assumes pads deliver three-state address pins as 2-bit codes and strap levels as inputs.
`timescale 1ns/100ps
module odac_ctrl
    import odac_pkg::*;
#(
    parameter int DAC_BITS = 16,
    parameter int CHANNELS = 8
) (
    input  wire logic                         clock_i,
    input  wire logic                         rst_n_i,
    input  wire logic                         scl_i,
    input  wire logic                         sda_i,
    output logic                              sda_o,
    output logic                              sda_oe_o,
    input  wire logic                         dac_load_strobe_n_i,
    input  wire logic [1:0]                   addr_select_pin_0_i,
    input  wire logic [1:0]                   addr_select_pin_1_i,
    input  wire logic [1:0]                   addr_select_pin_2_i,
    input  wire logic                         power_on_scale_select_i,
    input  wire logic                         reference_compensation_pin_i,
    output logic [CHANNELS*DAC_BITS-1:0]      dac_code_o,
    output logic [CHANNELS-1:0]               dac_power_down_o,
    output logic                              int_ref_on_o,
    output logic                              ext_ref_select_o
);
    import odac_pkg::*;

    localparam logic [DAC_BITS-1:0] MID_SCALE = {1'b1, {(DAC_BITS-1){1'b0}}};

    odac_rx_if link ();

    logic [SYNC_STAGES-1:0] dac_load_strobe_sync_reg;
    logic [SYNC_STAGES-1:0] por_sync_reg;
    logic [SYNC_STAGES-1:0] comp_sync_reg;
    logic                   dac_load_strobe_d_reg;
    logic [1:0]             init_cnt_reg;
    logic                   init_done_reg;
    logic                   frame_seen_reg;
    logic [6:0]             addr_reg;
    logic [DAC_BITS-1:0]    input_reg [CHANNELS];
    logic [DAC_BITS-1:0]    dac_reg   [CHANNELS];
    logic [CHANNELS-1:0]    pd_reg;
    logic                   int_ref_reg;
    logic                   ext_ref_reg;
    logic                   sda_oe_reg;

    odac_i2c_rx u_rx (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .link    (link)
    );

    // Command fields and decode
    wire [3:0]          cmd_w     = link.frame_word[CMD_MSB -: 4];
    wire [3:0]          ch_w      = link.frame_word[CH_MSB -: 4];
    wire [DAC_BITS-1:0] data_w    = link.frame_word[DATA_MSB -: DAC_BITS];
    wire                dac_load_strobe_q    = dac_load_strobe_sync_reg[SYNC_STAGES-1];
    wire                dac_load_strobe_fall = ~dac_load_strobe_q & dac_load_strobe_d_reg;
    wire                do_load   = dac_load_strobe_fall & frame_seen_reg;
    wire                cmd_v     = link.frame_valid & init_done_reg;
    wire                ch_ok     = (ch_w <= CH_LAST) | (ch_w == CH_ALL);
    wire                is_write  = cmd_v & ch_ok & ((cmd_w == ODAC_CMD_WRITE) |
                                    (cmd_w == ODAC_CMD_WRITE_UPD_ALL) | (cmd_w == ODAC_CMD_WRITE_UPD));
    wire                is_upd    = cmd_v & ch_ok & ((cmd_w == ODAC_CMD_UPDATE) | (cmd_w == ODAC_CMD_WRITE_UPD));
    wire                is_upd_all = cmd_v & ch_ok & (cmd_w == ODAC_CMD_WRITE_UPD_ALL);
    // Software power-down locked out while the strobe is held low
    wire                pd_ok     = cmd_v & dac_load_strobe_q;
    wire                is_pd_ch  = pd_ok & ch_ok & (cmd_w == ODAC_CMD_PD_CH);
    wire                is_pd_all = pd_ok & (cmd_w == ODAC_CMD_PD_CHIP);
    wire                strap_zero = ~por_sync_reg[SYNC_STAGES-1];

    // Synchronisers for the strobe and straps
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dac_load_strobe_sync_reg <= '1;
            por_sync_reg  <= '0;
            comp_sync_reg <= '1;
            dac_load_strobe_d_reg    <= 1'b1;
        end else begin
            dac_load_strobe_sync_reg <= {dac_load_strobe_sync_reg[SYNC_STAGES-2:0], dac_load_strobe_n_i};
            por_sync_reg  <= {por_sync_reg[SYNC_STAGES-2:0], power_on_scale_select_i};
            comp_sync_reg <= {comp_sync_reg[SYNC_STAGES-2:0], reference_compensation_pin_i};
            dac_load_strobe_d_reg    <= dac_load_strobe_q;
        end
    end

    // Own address from the three-state pins, re-evaluated every cycle
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            addr_reg <= 7'h00;
        else
            addr_reg <= odac_addr_lookup(addr_select_pin_2_i, addr_select_pin_1_i, addr_select_pin_0_i);
    end
    assign link.slave_addr = addr_reg;

    // Strap capture window after reset release
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            init_cnt_reg  <= 2'h0;
            init_done_reg <= 1'b0;
        end else if (!init_done_reg) begin
            init_cnt_reg  <= init_cnt_reg + 2'h1;
            init_done_reg <= (init_cnt_reg == 2'(INIT_CYCLES - 1));
        end
    end

    // Complete frame latch; a new frame in the load cycle wins
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            frame_seen_reg <= 1'b0;
        else if (link.frame_valid && init_done_reg)
            frame_seen_reg <= 1'b1;
        else if (do_load)
            frame_seen_reg <= 1'b0;
    end

    // Per-channel input and DAC registers with power state
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            wire sel = (ch_w == CH_ALL) | (ch_w == 4'(g));
            always_ff @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    input_reg[g] <= '0;
                    dac_reg[g]   <= '0;
                    pd_reg[g]    <= 1'b0;
                end else if (!init_done_reg) begin
                    input_reg[g] <= strap_zero ? '0 : MID_SCALE;
                    dac_reg[g]   <= strap_zero ? '0 : MID_SCALE;
                end else begin
                    if (is_write && sel)
                        input_reg[g] <= data_w;
                    if (do_load)
                        dac_reg[g] <= input_reg[g];
                    else if ((is_upd && sel) || is_upd_all)
                        dac_reg[g] <= (is_write && sel) ? data_w : input_reg[g];
                    if ((is_upd && sel) || is_upd_all)
                        pd_reg[g] <= 1'b0;
                    else if ((is_pd_ch && sel) || is_pd_all)
                        pd_reg[g] <= 1'b1;
                end
            end
            assign dac_code_o[g*DAC_BITS +: DAC_BITS] = dac_reg[g];
        end
    endgenerate

    // Reference state: strap picks the source at start with internal on; commands switch it, chip power-down turns internal off
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_ref_reg <= INT_REF_ON_RST;
            ext_ref_reg <= 1'b0;
        end else if (!init_done_reg) begin
            int_ref_reg <= INT_REF_ON_RST;
            ext_ref_reg <= ~comp_sync_reg[SYNC_STAGES-1];
        end else if (cmd_v && cmd_w == ODAC_CMD_REF_INT) begin
            int_ref_reg <= 1'b1;
            ext_ref_reg <= 1'b0;
        end else if (cmd_v && cmd_w == ODAC_CMD_REF_EXT) begin
            int_ref_reg <= 1'b0;
            ext_ref_reg <= 1'b1;
        end else if (is_pd_all) begin
            int_ref_reg <= 1'b0;
        end
    end

    // Pin output stage; data line only ever pulled low
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            sda_oe_reg <= 1'b0;
        else
            sda_oe_reg <= link.sda_oe;
    end

    assign sda_o            = 1'b0;
    assign sda_oe_o         = sda_oe_reg;
    assign dac_power_down_o = pd_reg;
    assign int_ref_on_o     = int_ref_reg;
    assign ext_ref_select_o = ext_ref_reg;

endmodule // odac_ctrl

//--- rtl/odac_i2c_rx.sv
// Write-only two-wire serial receiver of the octal DAC controller.
// Assumes raw bus levels on scl_i and sda_i; it synchronises them itself.
`timescale 1ns/100ps
module odac_i2c_rx
    import odac_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    odac_rx_if.rx     link
);
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_IGNORE = 3'b100
    } odac_rx_state_t;

    odac_rx_state_t   state_reg;
    logic [SYNC_STAGES-1:0] scl_sync_reg;
    logic [SYNC_STAGES-1:0] sda_sync_reg;
    logic             scl_d_reg;
    logic             sda_d_reg;
    logic [3:0]       bit_cnt_reg;
    logic [1:0]       byte_cnt_reg;
    logic [7:0]       shift_reg;
    logic [23:0]      word_reg;
    logic             oe_reg;
    logic             valid_reg;

    // Edge and condition detection from the synchronised samples only
    wire scl_q   = scl_sync_reg[SYNC_STAGES-1];
    wire sda_q   = sda_sync_reg[SYNC_STAGES-1];
    wire scl_rise = scl_q & ~scl_d_reg;
    wire scl_fall = ~scl_q & scl_d_reg;
    wire start_c  = scl_q & scl_d_reg & sda_d_reg & ~sda_q;
    wire stop_c   = scl_q & scl_d_reg & ~sda_d_reg & sda_q;
    wire addr_hit = (shift_reg[7:1] == link.slave_addr) & ~shift_reg[0]; // Reads are never claimed

    // Two-stage synchronisers, then one delay stage for edges
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_sync_reg <= '1;
            sda_sync_reg <= '1;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[SYNC_STAGES-2:0], scl_i};
            sda_sync_reg <= {sda_sync_reg[SYNC_STAGES-2:0], sda_i};
            scl_d_reg    <= scl_q;
            sda_d_reg    <= sda_q;
        end
    end

    // Bit, byte and acknowledge sequencing
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg    <= ST_IDLE;
            bit_cnt_reg  <= 4'h0;
            byte_cnt_reg <= 2'h0;
            shift_reg    <= 8'h00;
            word_reg     <= 24'h000000;
            oe_reg       <= 1'b0;
            valid_reg    <= 1'b0;
        end else begin
            valid_reg <= 1'b0;
            if (start_c) begin
                state_reg    <= ST_ACTIVE;
                bit_cnt_reg  <= 4'h0;
                byte_cnt_reg <= 2'h0;
                oe_reg       <= 1'b0;
            end else if (stop_c) begin
                state_reg <= ST_IDLE;
                oe_reg    <= 1'b0;
            end else begin
                case (state_reg)
                    ST_ACTIVE: begin
                        if (scl_rise) begin
                            if (bit_cnt_reg < 4'h8)
                                shift_reg <= {shift_reg[6:0], sda_q};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                            if (byte_cnt_reg != 2'h0) begin
                                oe_reg   <= 1'b1;
                                word_reg <= {word_reg[15:0], shift_reg};
                            end else if (addr_hit) begin
                                oe_reg <= 1'b1;
                            end else begin
                                state_reg <= ST_IGNORE;
                            end
                        end else if (scl_fall && bit_cnt_reg == 4'h9) begin
                            oe_reg      <= 1'b0;
                            bit_cnt_reg <= 4'h0;
                            // Further bytes restart a new three-byte frame
                            byte_cnt_reg <= (byte_cnt_reg == 2'(DATA_BYTES)) ? 2'h1 : byte_cnt_reg + 2'h1;
                            valid_reg    <= (byte_cnt_reg == 2'(DATA_BYTES));
                        end
                    end
                    ST_IDLE, ST_IGNORE: oe_reg <= 1'b0;
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end

    assign link.frame_valid = valid_reg;
    assign link.frame_word  = word_reg;
    assign link.sda_oe      = oe_reg;

endmodule // odac_i2c_rx

//--- rtl/odac_pkg.sv
// Shared constants of the octal DAC serial load controller.
// Assumes a 10 MHz system clock and pad-level decoding of the three-state address pins.
package odac_pkg;

    // Clock and synchroniser
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SYNC_STAGES    = 2;
    localparam int INIT_CYCLES    = 3;            // Straps settle through the synchroniser first

    // Command codes
    typedef enum logic [3:0] {
        ODAC_CMD_WRITE      = 4'h0,
        ODAC_CMD_UPDATE     = 4'h1,
        ODAC_CMD_WRITE_UPD_ALL = 4'h2,
        ODAC_CMD_WRITE_UPD  = 4'h3,
        ODAC_CMD_PD_CH      = 4'h4,
        ODAC_CMD_PD_CHIP    = 4'h5,
        ODAC_CMD_REF_INT    = 4'h6,
        ODAC_CMD_REF_EXT    = 4'h7,
        ODAC_CMD_NOP        = 4'hF
    } odac_cmd_t;

    localparam logic [3:0] CH_ALL        = 4'hF;
    localparam logic [3:0] CH_LAST       = 4'h7;

    // Three-state pin codes as presented by the pad detector
    localparam logic [1:0] PIN_GND       = 2'h0;
    localparam logic [1:0] PIN_FLOAT     = 2'h1;

    // Frame layout: command, channel, then two data bytes
    localparam int FRAME_BITS    = 24;
    localparam int CMD_MSB       = 23;
    localparam int CH_MSB        = 19;
    localparam int DATA_MSB      = 15;
    localparam int DATA_BYTES    = 3;

    // Reset values of the reference state
    localparam logic INT_REF_ON_RST = 1'b1;

    // Slave address per pin combination, index = ca2*9 + ca1*3 + ca0
    localparam logic [6:0] ADDR_TABLE [27] = '{
        7'h10, 7'h11, 7'h12, 7'h13, 7'h20, 7'h21, 7'h22, 7'h23, 7'h30,
        7'h31, 7'h32, 7'h33, 7'h40, 7'h41, 7'h42, 7'h43, 7'h50, 7'h51,
        7'h52, 7'h53, 7'h60, 7'h61, 7'h62, 7'h63, 7'h70, 7'h71, 7'h72
    };

    // Pin code to ternary digit; anything above float reads as tied high
    function automatic logic [4:0] odac_trit(input logic [1:0] code);
        odac_trit = (code == PIN_GND) ? 5'h00 : (code == PIN_FLOAT) ? 5'h01 : 5'h02;
    endfunction

    function automatic logic [6:0] odac_addr_lookup(input logic [1:0] ca2,
                                                     input logic [1:0] ca1,
                                                     input logic [1:0] ca0);
        logic [4:0] idx;
        idx = 5'(odac_trit(ca2) * 5'h09 + odac_trit(ca1) * 5'h03 + odac_trit(ca0));
        odac_addr_lookup = ADDR_TABLE[idx];
    endfunction

endpackage

//--- rtl/odac_rx_if.sv
// Link between the serial receiver and the command core.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface odac_rx_if;
    logic [6:0]  slave_addr;                      // Decoded own address
    logic        frame_valid;                     // One-cycle pulse per complete frame
    logic [23:0] frame_word;                      // Command, channel, data
    logic        sda_oe;                          // Acknowledge pull-down enable

    modport rx   (input slave_addr, output frame_valid, output frame_word, output sda_oe);
    modport core (output slave_addr, input frame_valid, input frame_word, input sda_oe);
endinterface // odac_rx_if

//--- testbench/odac_i2c_model.sv
// Two-wire bus master model writing frames to the DAC controller.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/100ps
module odac_i2c_model #(
    parameter int HALF = 8
) (
    input  wire logic clock_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_low_o
);
    // Idle bus: clock high, data released
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic start_cond;
        sda_low_o <= 1'b1;
        hold(HALF);
    endtask
    // Data bits move mid-low and the ack release one clock after the fall, so the rising edge always sees data settled
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            scl_o <= 1'b0;
            hold(HALF / 2);
            sda_low_o <= !b[i];
            hold(HALF / 2);
            scl_o <= 1'b1;
            hold(HALF);
        end
        scl_o <= 1'b0;
        hold(1);
        sda_low_o <= 1'b0;
        hold(HALF - 1);
        scl_o <= 1'b1;
        hold(HALF / 2);
        ack = !sda_i;
        hold(HALF / 2);
    endtask
    task automatic stop_cond;
        scl_o <= 1'b0;
        hold(HALF / 2);
        sda_low_o <= 1'b1;
        hold(HALF / 2);
        scl_o <= 1'b1;
        hold(HALF);
        sda_low_o <= 1'b0;
        hold(HALF);
    endtask
endmodule // odac_i2c_model

//--- testbench/odac_props.sv
// Port checker of the octal DAC controller, bound onto its top module.
// Assumes one clock domain and bus halves of 8 clocks from the bench.
`timescale 1ns/100ps
module odac_props #(
    parameter int DAC_BITS = 16,
    parameter int CHANNELS = 8
) (
    input wire logic                         clock_i,
    input wire logic                         rst_n_i,
    input wire logic                         scl_i,
    input wire logic                         sda_o,
    input wire logic                         sda_oe_o,
    input wire logic                         dac_load_strobe_n_i,
    input wire logic                         power_on_scale_select_i,
    input wire logic                         reference_compensation_pin_i,
    input wire logic [CHANNELS*DAC_BITS-1:0] dac_code_o,
    input wire logic [CHANNELS-1:0]          dac_power_down_o,
    input wire logic                         int_ref_on_o,
    input wire logic                         ext_ref_select_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic [3:0] ack_age_reg;
    logic [3:0] load_age_reg;
    logic [3:0] up_age_reg;

    // Ages of last acknowledge release, strobe fall and reset release
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_age_reg  <= 4'hF;
            load_age_reg <= 4'hF;
            up_age_reg   <= 4'h0;
        end else begin
            ack_age_reg  <= $fell(sda_oe_o) ? 4'h0 : ack_age_reg + 4'(ack_age_reg != 4'hF);
            load_age_reg <= $fell(dac_load_strobe_n_i) ? 4'h0 : load_age_reg + 4'(load_age_reg != 4'hF);
            up_age_reg   <= up_age_reg + 4'(up_age_reg != 4'hF);
        end
    end

    // Straps land a few clocks after release
    sequence s_reset_gone;
        $rose(rst_n_i);
    endsequence
    property p_scale; s_reset_gone |-> ##6 dac_code_o == {CHANNELS{power_on_scale_select_i, {(DAC_BITS-1){1'b0}}}}; endproperty
    property p_ref_start; s_reset_gone |-> ##6 (int_ref_on_o && ext_ref_select_o == !reference_compensation_pin_i); endproperty
    property p_sda_value; sda_o == 1'b0; endproperty
    property p_ack_rise; $rose(sda_oe_o) |-> !scl_i && $past(!scl_i, 2); endproperty
    property p_ack_drop; $fell(sda_oe_o) |-> !scl_i; endproperty
    property p_ack_hold; $rose(sda_oe_o) |-> sda_oe_o [*8]; endproperty
    property p_ack_steady; scl_i && $past(scl_i, 3) |-> $stable(sda_oe_o); endproperty
    property p_pd_locked; !dac_load_strobe_n_i [*6] |-> (dac_power_down_o & ~$past(dac_power_down_o)) == '0; endproperty
    // Codes move only after a frame, a strobe fall or the power-on load
    // Frame updates land in the same cycle as the last acknowledge release, so that fall counts directly
    property p_code_cause; $changed(dac_code_o) |-> ($fell(sda_oe_o) || ack_age_reg < 4'h6 || load_age_reg < 4'h6 ||
        up_age_reg < 4'h8); endproperty

    a_scale: assert property (p_scale) else $error("power-on codes wrong");
    a_ref_start: assert property (p_ref_start) else $error("start reference wrong");
    a_sda_value: assert property (p_sda_value) else $error("data line driven high");
    a_ack_rise: assert property (p_ack_rise) else $error("ack began with clock high");
    a_ack_drop: assert property (p_ack_drop) else $error("ack ended with clock high");
    a_ack_hold: assert property (p_ack_hold) else $error("ack too short");
    a_ack_steady: assert property (p_ack_steady) else $error("data line moved in clock high");
    a_pd_locked: assert property (p_pd_locked) else $error("power down under low strobe");
    a_code_cause: assert property (p_code_cause) else $error("codes changed without cause");
endmodule // odac_props

bind odac_ctrl odac_props #(.DAC_BITS(DAC_BITS), .CHANNELS(CHANNELS)) props_u (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .dac_load_strobe_n_i(dac_load_strobe_n_i), .power_on_scale_select_i(power_on_scale_select_i),
    .reference_compensation_pin_i(reference_compensation_pin_i), .dac_code_o(dac_code_o),
    .dac_power_down_o(dac_power_down_o), .int_ref_on_o(int_ref_on_o), .ext_ref_select_o(ext_ref_select_o)
);

//--- testbench/test_odac_ctrl.sv
// Self-checking bench of the octal DAC controller: straps, address, frames, load strobe.
// Assumes the bus master model and the bound checker are compiled before it.
`timescale 1ns/100ps
module test_odac_ctrl;
    localparam logic [5:0] PINS [6]  = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h05, 6'h06};
    localparam logic [6:0] ADDRS [6] = '{7'h10, 7'h11, 7'h12, 7'h13, 7'h20, 7'h21};
    logic         clock_i, rst_n_i, strobe_n, scale_sel, comp_pin, scl, sda_low, sda_o, sda_oe;
    logic [1:0]   ca0, ca1, ca2;
    logic [127:0] dac_code;
    logic [7:0]   pd, exp_pd;
    logic         int_ref, ext_ref, exp_int, exp_ext, armed, hit;
    logic [15:0]  exp_in [8];
    logic [15:0]  exp_dac [8];
    logic [3:0]   acks;
    logic [2:0]   res;
    int           n_mismatch, check_count;
    wire          sda_wire = !(sda_low || (sda_oe && sda_o == 1'b0));

    // Design and its bus master share the resolved data wire
    odac_ctrl dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o),
        .sda_oe_o(sda_oe), .dac_load_strobe_n_i(strobe_n), .addr_select_pin_0_i(ca0),
        .addr_select_pin_1_i(ca1), .addr_select_pin_2_i(ca2), .power_on_scale_select_i(scale_sel),
        .reference_compensation_pin_i(comp_pin), .dac_code_o(dac_code), .dac_power_down_o(pd),
        .int_ref_on_o(int_ref), .ext_ref_select_o(ext_ref));
    odac_i2c_model bus (.clock_i(clock_i), .sda_i(sda_wire), .scl_o(scl), .sda_low_o(sda_low));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic check_outs;
        for (int g = 0; g < 8; g++) check("code", exp_dac[g], dac_code[16*g +: 16]);
        check("power down", {8'h00, exp_pd}, {8'h00, pd});
        check("reference", {14'h0000, exp_int, exp_ext}, {14'h0000, int_ref, ext_ref});
    endtask
    task automatic stop_test;
        $display("mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Whole frame of nb bytes; trailing gap covers the strobe hold-off
    task automatic frame(input logic [6:0] a, input logic rw, input logic [23:0] w, input int nb);
        logic ack;
        acks = 4'h0;
        bus.start_cond();
        bus.send_byte({a, rw}, ack);
        acks[0] = ack;
        for (int i = 1; i < nb; i++) begin
            bus.send_byte(w[31-8*i -: 8], ack);
            acks[i] = ack;
        end
        bus.stop_cond();
        repeat (6) @(posedge clock_i);
    endtask
    // One command frame, then the expected state is stepped and compared
    task automatic send(input logic [3:0] cmd, input logic [3:0] ch, input logic [15:0] d);
        frame(7'h21, 1'b0, {cmd, ch, d}, 4);
        check("frame acks", 16'h000F, {12'h000, acks});
        armed = 1'b1;
        for (int g = 0; g < 8; g++) begin
            hit = (ch == 4'hF || ch == 4'(g));
            if (hit && cmd inside {4'h0, 4'h2, 4'h3}) exp_in[g] = d;
            if ((hit && cmd inside {4'h1, 4'h3}) || cmd == 4'h2) begin
                exp_dac[g] = exp_in[g];
                exp_pd[g] = 1'b0;
            end
            if (((hit && cmd == 4'h4) || cmd == 4'h5) && strobe_n) exp_pd[g] = 1'b1;
        end
        if (cmd == 4'h5 && strobe_n) exp_int = 1'b0;
        if (cmd inside {4'h6, 4'h7}) begin
            exp_int = !cmd[0];
            exp_ext = cmd[0];
        end
        check_outs();
    endtask
    task automatic strobe_to(input logic level);
        repeat (8) @(posedge clock_i);
        strobe_n <= level;
        repeat (8) @(posedge clock_i);
        if (!level && armed) for (int g = 0; g < 8; g++) exp_dac[g] = exp_in[g];
        if (!level) armed = 1'b0;
        check_outs();
    endtask
    task automatic do_reset(input logic scale, input logic comp);
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        scale_sel <= scale;
        comp_pin <= comp;
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        for (int g = 0; g < 8; g++) exp_dac[g] = {scale, 15'h0000};
        exp_in = exp_dac;
        {exp_pd, exp_int, exp_ext, armed} = {8'h00, 1'b1, !comp, 1'b0};
        check_outs();
    endtask

    // Free-running 10 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end
    initial begin
        {rst_n_i, strobe_n, scale_sel, comp_pin, ca0, ca1, ca2} = {4'b0100, 6'h00};
        n_mismatch = 0;
        check_count = 0;
        do_reset(1'b0, 1'b1);
        // Each strap set acks its own write only, never another address or a read
        for (int e = 0; e < 6; e++) begin
            {ca2, ca1, ca0} <= PINS[e];
            repeat (4) @(posedge clock_i);
            frame(ADDRS[e], 1'b0, 24'h000000, 1);
            res[2] = acks[0];
            frame(ADDRS[e] + 7'h40, 1'b0, 24'h000000, 1);
            res[1] = acks[0];
            frame(ADDRS[e], 1'b1, 24'h000000, 1);
            res[0] = acks[0];
            check("address acks", 16'h0004, {13'h0000, res});
        end
        send(4'h3, 4'hF, 16'h0F0F);
        send(4'h2, 4'h0, 16'hAAAA);
        send(4'h0, 4'h2, 16'h1234);
        strobe_to(1'b0);
        strobe_to(1'b1);
        strobe_to(1'b0);
        send(4'h0, 4'h5, 16'h5A5A);
        send(4'h4, 4'h1, 16'h0000);
        send(4'h5, 4'h0, 16'h0000);
        strobe_to(1'b1);
        strobe_to(1'b0);
        strobe_to(1'b1);
        send(4'h4, 4'h1, 16'h0000);
        send(4'h1, 4'h1, 16'h0000);
        send(4'h5, 4'h0, 16'h0000);
        send(4'h3, 4'h3, 16'hBEEF);
        send(4'h6, 4'h0, 16'h0000);
        send(4'h7, 4'h0, 16'h0000);
        send(4'h9, 4'h2, 16'h3333);
        send(4'h0, 4'h9, 16'h4444);
        send(4'hF, 4'hF, 16'h5555);
        do_reset(1'b1, 1'b0);
        stop_test();
    end
endmodule // test_odac_ctrl
